// >>> hdl/ioxb_pkg.sv
package ioxb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // system port numbers, exact eight-bit decode
  localparam logic [7:0] PORT_INT = 8'he0;
  localparam logic [7:0] PORT_NMI = 8'he4;
  localparam logic [7:0] PORT_OPT = 8'hec;
  localparam logic [7:0] PORT_DRV = 8'hf4;
  localparam logic [7:0] PORT_TAPE = 8'hff;
  // port numbers with this bit set belong to the system
  localparam int SYS_PORT_BIT = 7;

  ////////////////////////////////////////////////////////////////////////////
  // option port fields
  localparam int OPT_VIDEO_WAIT = 5;
  localparam int OPT_EXT_BUS = 4;
  localparam int OPT_ALT_CHARSET = 3;
  localparam int OPT_COLUMN = 2;
  localparam int OPT_MOTOR = 1;
  localparam logic [7:0] OPT_KEEP = 8'h3e;

  // interrupt mask and status fields
  localparam int INT_SERIAL_FAULT = 6;
  localparam int INT_SERIAL_RX = 5;
  localparam int INT_SERIAL_TX = 4;
  localparam int INT_EXPANSION = 3;
  localparam int INT_TICK = 2;
  localparam int INT_TAPE_FALL = 1;
  localparam int INT_TAPE_RISE = 0;
  localparam logic [7:0] INT_KEEP = 8'h7f;

  // nmi mask and status fields
  localparam int NMI_DISK_DONE = 7;
  localparam int NMI_DISK_DATA = 6;
  localparam int NMI_RESET = 5;
  localparam logic [7:0] NMI_KEEP = 8'hc0;

  // tape ports
  localparam int TAPE_LOW_SPEED = 7;
  localparam int TAPE_HIGH_SPEED = 0;
  localparam logic [7:0] TAPE_OUT_KEEP = 8'h03;

  // drive select fields
  localparam int DRV_DENSITY = 7;
  localparam int DRV_STALL = 6;
  localparam int DRV_WRITE_A = 5;
  localparam int DRV_SIDE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_NMI_MASK = 8'h00;
  localparam logic [7:0] RST_OPT = 8'h00;
  localparam logic [7:0] RST_DRV = 8'h00;
  localparam logic [7:0] RST_TAPE_OUT = 8'h00;
  // value a cpu read sees when nobody answers
  localparam logic [7:0] FLOAT_DATA = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // registered bus-facing signals
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic drive_n;
    logic in_n;
    logic out_n;
    logic port_request_n_n;
    logic m1_n;
    logic reset_n;
  } ioxb_bus_t;

  // whole module state
  typedef struct packed {
    ioxb_bus_t bus;
    logic [7:0] int_mask;
    logic [7:0] nmi_mask;
    logic [7:0] opt;
    logic [7:0] drv;
    logic [7:0] tape_out;
    logic tape_rise;
    logic tape_fall;
    logic tape_low;
    logic tape_hs_q;
    logic rd_q;
    logic wr_q;
    logic [7:0] rdata;
    logic rdata_oe_n;
    logic wait_n;
    logic int_n;
    logic nmi_n;
  } ioxb_state_t;

endpackage : ioxb_pkg

// >>> hdl/ioxb_port_logic.sv
// Summary of operation
// - bus address, data and control reach the connector only with external bus enabled
// - eight port lines select 256 ports; a bus acknowledge overrides system ports 80h to ffh on reads
// - bus data moves to and from the cpu only with external bus enabled
// - separate active-low input and output strobes, each qualified by port request
// - external device pulls read acknowledge low; transceiver then feeds cpu
// - bus wait reaches cpu wait only with external bus enabled
// - bus interrupt reaches cpu only when interrupt mask bit 3 is set
// - bus interrupt line state readable in status even while masked
// - write-only nmi mask: bit 7 disk completion, bit 6 disk data
// - nmi status: bit 7 completion, 6 data, 5 reset; zero means true
// - option port holds video wait, bus enable, charset, columns, tape motor
// - interrupt status reads active-low pending flags, bits 6 down to 0
// - interrupt mask write sets per-source enables, one means enabled
// - tape output port latches data bits 1 and 0 only
// - tape input read: low speed bit 7, high speed bit 0, option bits 5-1
// - any tape input read clears both high speed edge interrupts
// - drive select latches density, stall, write a, side and four drive selects
`timescale 1ns/1ps
`default_nettype none

module ioxb_port_logic
  import ioxb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // cpu side
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_port_request_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_opcode_fetch_n,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_oe_n,
  output logic cpu_wait_n,
  output logic cpu_int_n,
  output logic cpu_nmi_n,
  // expansion connector
  output logic [7:0] port_select_lines,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe_n,
  input wire logic [7:0] bus_data_in,
  output logic bus_in_strobe_n,
  output logic bus_out_strobe_n,
  output logic bus_port_request_n,
  output logic bus_opcode_fetch_n,
  output logic bus_reset_n,
  output logic bus_ctrl_oe_n,
  input wire logic external_read_ack_n,
  input wire logic expansion_stall_n,
  input wire logic expansion_irq_n,
  // interrupt and nmi sources
  input wire logic serial_fault_req,
  input wire logic serial_rx_req,
  input wire logic serial_tx_req,
  input wire logic tick_req,
  input wire logic disk_completion_request,
  input wire logic disk_data_request,
  input wire logic reset_switch_n,
  // tape inputs and outputs
  input wire logic tape_high_speed_in,
  input wire logic tape_low_speed_set,
  output logic [1:0] tape_output_level,
  // option outputs
  output logic video_wait_enable,
  output logic external_bus_enable,
  output logic alternate_charset_enable,
  output logic column_width_select,
  output logic tape_motor_on,
  // drive select outputs
  output logic density_select,
  output logic disk_stall_generate,
  output logic write_enable_a,
  output logic diskette_side_select,
  output logic [3:0] drive_select
);

  ////////////////////////////////////////////////////////////////////////////
  // state and next state
  ioxb_state_t st;
  ioxb_state_t next_st;

  // cycle decode from the cpu pins
  logic port_rd;
  logic port_wr;
  logic rd_start;
  logic wr_start;
  logic ext_en;
  logic sys_port;
  logic ext_answer;
  logic [7:0] int_status;
  logic [7:0] nmi_status;
  logic [7:0] tape_in;
  logic [7:0] sys_rdata;
  logic sys_hit;
  logic hs_rise;
  logic hs_fall;

  ////////////////////////////////////////////////////////////////////////////
  // port cycle qualification
  assign port_rd = !cpu_port_request_n && !cpu_rd_n && cpu_opcode_fetch_n;
  assign port_wr = !cpu_port_request_n && !cpu_wr_n && cpu_opcode_fetch_n;
  // first cycle of each access, so a write stores once
  assign rd_start = port_rd && !st.rd_q;
  assign wr_start = port_wr && !st.wr_q;
  assign ext_en = st.opt[OPT_EXT_BUS];
  assign sys_port = cpu_addr[SYS_PORT_BIT];
  // transceiver turns toward the cpu only on acknowledge
  assign ext_answer = ext_en && port_rd && !external_read_ack_n;

  // high speed tape edges
  assign hs_rise = tape_high_speed_in && !st.tape_hs_q;
  assign hs_fall = !tape_high_speed_in && st.tape_hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // readable status words
  always_comb begin
    int_status = 8'hff;
    // active-low pending flags
    int_status[INT_SERIAL_FAULT] = !serial_fault_req;
    int_status[INT_SERIAL_RX] = !serial_rx_req;
    int_status[INT_SERIAL_TX] = !serial_tx_req;
    // raw bus line, independent of its mask
    int_status[INT_EXPANSION] = expansion_irq_n;
    int_status[INT_TICK] = !tick_req;
    int_status[INT_TAPE_FALL] = !st.tape_fall;
    int_status[INT_TAPE_RISE] = !st.tape_rise;
  end

  always_comb begin
    nmi_status = 8'hff;
    nmi_status[NMI_DISK_DONE] = !disk_completion_request;
    nmi_status[NMI_DISK_DATA] = !disk_data_request;
    nmi_status[NMI_RESET] = reset_switch_n;
  end

  always_comb begin
    // option bits read back in their own places
    tape_in = st.opt & OPT_KEEP;
    tape_in[TAPE_LOW_SPEED] = st.tape_low;
    tape_in[TAPE_HIGH_SPEED] = tape_high_speed_in;
  end

  // system read mux; write-only ports do not answer
  always_comb begin
    sys_hit = 1'b1;
    unique case (cpu_addr)
      PORT_INT: sys_rdata = int_status;
      PORT_NMI: sys_rdata = nmi_status;
      PORT_TAPE: sys_rdata = tape_in;
      default: begin
        sys_rdata = FLOAT_DATA;
        sys_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    next_st.rd_q = port_rd;
    next_st.wr_q = port_wr;
    next_st.tape_hs_q = tape_high_speed_in;

    // register writes on the first cycle of an output
    if (wr_start) begin
      unique case (cpu_addr)
        PORT_INT: next_st.int_mask = cpu_wdata & INT_KEEP;
        PORT_NMI: next_st.nmi_mask = cpu_wdata & NMI_KEEP;
        PORT_OPT: next_st.opt = cpu_wdata & OPT_KEEP;
        PORT_DRV: next_st.drv = cpu_wdata;
        PORT_TAPE: next_st.tape_out = cpu_wdata & TAPE_OUT_KEEP;
        default: next_st.int_mask = st.int_mask;
      endcase
    end

    // tape latches: read of tape port clears, a new edge wins
    if (rd_start && cpu_addr == PORT_TAPE) begin
      next_st.tape_rise = 1'b0;
      next_st.tape_fall = 1'b0;
      next_st.tape_low = 1'b0;
    end
    if (hs_rise) begin
      next_st.tape_rise = 1'b1;
    end
    if (hs_fall) begin
      next_st.tape_fall = 1'b1;
    end
    if (tape_low_speed_set) begin
      next_st.tape_low = 1'b1;
    end

    // cpu read data
    next_st.rdata_oe_n = 1'b1;
    next_st.rdata = st.rdata;
    if (port_rd) begin
      next_st.rdata_oe_n = 1'b0;
      if (ext_answer) begin
        next_st.rdata = bus_data_in;
      end else if (sys_port && sys_hit) begin
        // system word taken once, before the tape read clears its latches
        if (rd_start) begin
          next_st.rdata = sys_rdata;
        end
      end else begin
        next_st.rdata = FLOAT_DATA;
      end
    end

    // buffered bus outputs, idle unless the external bus is on
    next_st.bus.addr = 8'h00;
    next_st.bus.wdata = 8'h00;
    next_st.bus.drive_n = 1'b1;
    next_st.bus.in_n = 1'b1;
    next_st.bus.out_n = 1'b1;
    next_st.bus.port_request_n_n = 1'b1;
    next_st.bus.m1_n = 1'b1;
    next_st.bus.reset_n = 1'b1;
    if (ext_en) begin
      next_st.bus.addr = cpu_addr;
      next_st.bus.port_request_n_n = cpu_port_request_n;
      next_st.bus.m1_n = cpu_opcode_fetch_n;
      next_st.bus.reset_n = 1'b1;
      // strobes gated with port request
      next_st.bus.in_n = cpu_port_request_n || cpu_rd_n;
      next_st.bus.out_n = cpu_port_request_n || cpu_wr_n;
      if (port_wr) begin
        next_st.bus.wdata = cpu_wdata;
        next_st.bus.drive_n = 1'b0;
      end
    end

    // wait from the bus only when enabled
    next_st.wait_n = !ext_en || expansion_stall_n;

    // masked interrupt, mode 1 request to the cpu
    next_st.int_n = !(|(~int_status & st.int_mask & INT_KEEP));

    // nmi from the disk sources
    next_st.nmi_n = !((disk_completion_request && st.nmi_mask[NMI_DISK_DONE]) ||
                      (disk_data_request && st.nmi_mask[NMI_DISK_DATA]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st.bus.addr <= 8'h00;
      st.bus.wdata <= 8'h00;
      st.bus.drive_n <= 1'b1;
      st.bus.in_n <= 1'b1;
      st.bus.out_n <= 1'b1;
      st.bus.port_request_n_n <= 1'b1;
      st.bus.m1_n <= 1'b1;
      st.bus.reset_n <= 1'b0;
      st.int_mask <= RST_INT_MASK;
      st.nmi_mask <= RST_NMI_MASK;
      st.opt <= RST_OPT;
      st.drv <= RST_DRV;
      st.tape_out <= RST_TAPE_OUT;
      st.tape_rise <= 1'b0;
      st.tape_fall <= 1'b0;
      st.tape_low <= 1'b0;
      st.tape_hs_q <= 1'b0;
      st.rd_q <= 1'b0;
      st.wr_q <= 1'b0;
      st.rdata <= FLOAT_DATA;
      st.rdata_oe_n <= 1'b1;
      st.wait_n <= 1'b1;
      st.int_n <= 1'b1;
      st.nmi_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu side outputs
  assign cpu_rdata = st.rdata;
  assign cpu_rdata_oe_n = st.rdata_oe_n;
  assign cpu_wait_n = st.wait_n;
  assign cpu_int_n = st.int_n;
  assign cpu_nmi_n = st.nmi_n;

  // connector outputs; control buffers off while the bus is disabled
  assign port_select_lines = st.bus.addr;
  assign bus_data_out = st.bus.wdata;
  assign bus_data_oe_n = st.bus.drive_n;
  assign bus_in_strobe_n = st.bus.in_n;
  assign bus_out_strobe_n = st.bus.out_n;
  assign bus_port_request_n = st.bus.port_request_n_n;
  assign bus_opcode_fetch_n = st.bus.m1_n;
  assign bus_reset_n = st.bus.reset_n;
  assign bus_ctrl_oe_n = !ext_en;

  // tape and option outputs
  assign tape_output_level = st.tape_out[1:0];
  assign video_wait_enable = st.opt[OPT_VIDEO_WAIT];
  assign external_bus_enable = st.opt[OPT_EXT_BUS];
  assign alternate_charset_enable = st.opt[OPT_ALT_CHARSET];
  assign column_width_select = st.opt[OPT_COLUMN];
  assign tape_motor_on = st.opt[OPT_MOTOR];

  // drive select outputs
  assign density_select = st.drv[DRV_DENSITY];
  assign disk_stall_generate = st.drv[DRV_STALL];
  assign write_enable_a = st.drv[DRV_WRITE_A];
  assign diskette_side_select = st.drv[DRV_SIDE];
  assign drive_select = st.drv[3:0];

endmodule : ioxb_port_logic

`default_nettype wire

// >>> sim/ioxb_ext_board.sv
`timescale 1ns/1ps
`default_nettype none

module ioxb_ext_board #(
  parameter logic [7:0] MY_PORT = 8'h10,
  parameter logic [7:0] MY_DATA = 8'h5a
) (
  // connector from the host
  input wire logic [7:0] port_select_lines,
  input wire logic bus_in_strobe_n,
  input wire logic bus_ctrl_oe_n,
  // bench controls
  input wire logic stall_req,
  input wire logic irq_req,
  // back to the host
  output logic external_read_ack_n,
  output logic [7:0] bus_data_in,
  output logic expansion_stall_n,
  output logic expansion_irq_n
);
  logic hit;
  // decode a user port only, never the system range
  assign hit = !bus_ctrl_oe_n && !port_select_lines[7] && port_select_lines == MY_PORT;
  // acknowledge as nand of input strobe and match
  assign external_read_ack_n = !(!bus_in_strobe_n && hit);
  // drive data only while addressed, else a changed pattern
  assign bus_data_in = (!bus_in_strobe_n && hit) ? MY_DATA : ~MY_DATA;
  // stall and interrupt follow the bench
  assign expansion_stall_n = !stall_req;
  assign expansion_irq_n = !irq_req;
endmodule : ioxb_ext_board

`default_nettype wire

// >>> sim/ioxb_port_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ioxb_port_logic_bench;
  import ioxb_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00;
  logic cpu_port_request_n = 1'b1, cpu_rd_n = 1'b1, cpu_wr_n = 1'b1;
  logic [3:0] src = 4'h0;
  logic disk_completion_request = 1'b0, disk_data_request = 1'b0, reset_switch_n = 1'b1;
  logic tape_high_speed_in = 1'b0, tape_low_speed_set = 1'b0, stall_req = 1'b0;
  logic irq_req = 1'b0;
  logic [7:0] cpu_rdata, port_select_lines, bus_data_in, drv, v;
  logic cpu_wait_n, cpu_int_n, cpu_nmi_n, bus_in_strobe_n, bus_ctrl_oe_n;
  logic external_read_ack_n, expansion_stall_n, expansion_irq_n;
  logic [1:0] tape_output_level;
  logic [4:0] opt;
  int mismatches = 0;
  int samples_checked = 0;
  int pos[4] = '{6, 5, 4, 2};

  always #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  ioxb_port_logic dut (.mclk, .rst_b, .cpu_addr, .cpu_wdata, .cpu_port_request_n,
    .cpu_rd_n, .cpu_wr_n, .cpu_opcode_fetch_n(1'b1), .cpu_rdata, .cpu_rdata_oe_n(),
    .cpu_wait_n, .cpu_int_n, .cpu_nmi_n, .port_select_lines, .bus_data_out(),
    .bus_data_oe_n(), .bus_data_in, .bus_in_strobe_n, .bus_out_strobe_n(),
    .bus_port_request_n(), .bus_opcode_fetch_n(), .bus_reset_n(), .bus_ctrl_oe_n,
    .external_read_ack_n, .expansion_stall_n, .expansion_irq_n, .serial_fault_req(src[0]),
    .serial_rx_req(src[1]), .serial_tx_req(src[2]), .tick_req(src[3]),
    .disk_completion_request, .disk_data_request, .reset_switch_n, .tape_high_speed_in,
    .tape_low_speed_set, .tape_output_level, .video_wait_enable(opt[4]),
    .external_bus_enable(opt[3]), .alternate_charset_enable(opt[2]),
    .column_width_select(opt[1]), .tape_motor_on(opt[0]), .density_select(drv[7]),
    .disk_stall_generate(drv[6]), .write_enable_a(drv[5]), .diskette_side_select(drv[4]),
    .drive_select(drv[3:0]));
  ioxb_ext_board board (.port_select_lines, .bus_in_strobe_n, .bus_ctrl_oe_n, .stall_req,
    .irq_req, .external_read_ack_n, .bus_data_in, .expansion_stall_n, .expansion_irq_n);

  ////////////////////////////////////////////////////////////////////////////
  // comparisons of bytes and of flags
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic flag(input string what, input logic exp, input logic got);
    chk(what, {7'h0, exp}, {7'h0, got});
  endtask : flag

  // one port write, held for a single edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_port_request_n <= 1'b0;
    cpu_wr_n <= 1'b0;
    @(posedge mclk);
    cpu_port_request_n <= 1'b1;
    cpu_wr_n <= 1'b1;
    @(posedge mclk);
    #1;
  endtask : wr

  // one port read, held three edges so the board can answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_port_request_n <= 1'b0;
    cpu_rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    cpu_port_request_n <= 1'b1;
    cpu_rd_n <= 1'b1;
    #1;
    chk(what, exp, cpu_rdata);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(PORT_INT, 8'hff, "int status idle");
    rd(PORT_TAPE, 8'h00, "tape in idle");
    rd(8'h10, FLOAT_DATA, "bus read off");
    wr(PORT_OPT, 8'h10);
    flag("ctrl oe", 1'b0, bus_ctrl_oe_n);
    rd(8'h10, 8'h5a, "bus read");
    wr(8'h10, 8'h33);
    for (int i = 1; i < 6; i++) begin
      v = 8'h10 | (8'h01 << i);
      wr(PORT_OPT, v);
      chk("option outs", v & OPT_KEEP, {2'b0, opt, 1'b0});
      rd(PORT_TAPE, v & OPT_KEEP, "option readback");
    end
    $display("test bus and options done");
    @(posedge mclk) stall_req <= 1'b1;
    settle;
    flag("wait on", 1'b0, cpu_wait_n);
    wr(PORT_OPT, 8'h00);
    flag("wait gated", 1'b1, cpu_wait_n);
    @(posedge mclk) stall_req <= 1'b0;
    wr(PORT_OPT, 8'h10);
    @(posedge mclk) irq_req <= 1'b1;
    settle;
    flag("irq masked", 1'b1, cpu_int_n);
    rd(PORT_INT, 8'hf7, "bus irq status");
    wr(PORT_INT, 8'h08);
    flag("irq passed", 1'b0, cpu_int_n);
    @(posedge mclk) irq_req <= 1'b0;
    settle;
    flag("irq gone", 1'b1, cpu_int_n);
    wr(PORT_INT, INT_KEEP);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) src <= 4'h1 << i;
      settle;
      flag("source irq", 1'b0, cpu_int_n);
      rd(PORT_INT, ~(8'h01 << pos[i]), "source status");
    end
    @(posedge mclk) src <= 4'h0;
    $display("test wait and interrupts done");
    @(posedge mclk) tape_high_speed_in <= 1'b1;
    settle;
    rd(PORT_INT, 8'hfe, "tape rise");
    @(posedge mclk) tape_high_speed_in <= 1'b0;
    tape_low_speed_set <= 1'b1;
    @(posedge mclk) tape_low_speed_set <= 1'b0;
    settle;
    rd(PORT_INT, 8'hfc, "tape both");
    rd(PORT_TAPE, 8'h90, "tape in");
    rd(PORT_INT, 8'hff, "tape cleared");
    $display("test tape done");
    wr(PORT_NMI, NMI_KEEP);
    @(posedge mclk) disk_completion_request <= 1'b1;
    reset_switch_n <= 1'b0;
    settle;
    flag("nmi done", 1'b0, cpu_nmi_n);
    rd(PORT_NMI, 8'h5f, "nmi status");
    @(posedge mclk) disk_completion_request <= 1'b0;
    disk_data_request <= 1'b1;
    reset_switch_n <= 1'b1;
    wr(PORT_NMI, 8'h40);
    flag("nmi data", 1'b0, cpu_nmi_n);
    rd(PORT_NMI, 8'hbf, "nmi status data");
    wr(PORT_NMI, 8'h80);
    flag("nmi masked", 1'b1, cpu_nmi_n);
    @(posedge mclk) disk_data_request <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h5a : 8'ha5;
      wr(PORT_DRV, v);
      chk("drive select", v, drv);
      wr(PORT_TAPE, ~v);
      chk("tape out", {6'h0, ~v[1:0]}, {6'h0, tape_output_level});
    end
    $display("test nmi, drive and tape out done");
    print_verdict;
  end

  // watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end

endmodule : ioxb_port_logic_bench

`default_nettype wire

// >>> sim/ioxb_port_logic_properties.sv
`timescale 1ns/1ps
`default_nettype none

module ioxb_port_logic_properties
  import ioxb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // cpu side
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_port_request_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_opcode_fetch_n,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rdata_oe_n,
  input wire logic cpu_wait_n,
  input wire logic cpu_nmi_n,
  // connector, sources and latches
  input wire logic bus_in_strobe_n,
  input wire logic bus_out_strobe_n,
  input wire logic bus_ctrl_oe_n,
  input wire logic [7:0] bus_data_in,
  input wire logic external_read_ack_n,
  input wire logic expansion_stall_n,
  input wire logic disk_completion_request,
  input wire logic disk_data_request,
  input wire logic external_bus_enable,
  input wire logic [1:0] tape_output_level
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // port cycles as the cpu presents them
  logic rd_go;
  logic wr_go;
  assign rd_go = !cpu_port_request_n && !cpu_rd_n && cpu_opcode_fetch_n;
  assign wr_go = !cpu_port_request_n && !cpu_wr_n && cpu_opcode_fetch_n;

  ////////////////////////////////////////////////////////////////////////////
  a_ctrl_oe_follow: assert property (bus_ctrl_oe_n == !external_bus_enable)
    else $error("connector buffers disagree with option bit");
  a_bus_idle_off: assert property (!external_bus_enable && !$past(external_bus_enable)
    |-> bus_in_strobe_n && bus_out_strobe_n) else $error("strobe while bus off");
  a_in_strobe_mirror: assert property (external_bus_enable && $past(external_bus_enable)
    |-> bus_in_strobe_n == ($past(cpu_port_request_n) | $past(cpu_rd_n)))
    else $error("input strobe wrong");
  a_out_strobe_mirror: assert property (external_bus_enable && $past(external_bus_enable)
    |-> bus_out_strobe_n == ($past(cpu_port_request_n) | $past(cpu_wr_n)))
    else $error("output strobe wrong");
  a_wait_gate: assert property (external_bus_enable == $past(external_bus_enable)
    |-> cpu_wait_n == (!external_bus_enable || $past(expansion_stall_n)))
    else $error("cpu wait wrong");
  a_nmi_quiet: assert property (!$past(disk_completion_request)
    && !$past(disk_data_request) |-> cpu_nmi_n) else $error("nmi without source");
  a_read_oe_timing: assert property (cpu_rdata_oe_n == !$past(rd_go))
    else $error("read enable timing wrong");
  a_ext_read_data: assert property (rd_go && !cpu_addr[7] && !external_read_ack_n
    && external_bus_enable |=> cpu_rdata == $past(bus_data_in))
    else $error("bus read data lost");
  a_tape_out_latch: assert property ($changed(tape_output_level) |-> $past(wr_go)
    && $past(cpu_addr) == PORT_TAPE && tape_output_level == $past(cpu_wdata[1:0]))
    else $error("tape level changed wrongly");
  a_bus_enable_write: assert property ($changed(external_bus_enable) |-> $past(wr_go)
    && $past(cpu_addr) == PORT_OPT && external_bus_enable == $past(cpu_wdata[4]))
    else $error("bus enable changed wrongly");

endmodule : ioxb_port_logic_properties

bind ioxb_port_logic ioxb_port_logic_properties u_props (.mclk, .rst_b, .cpu_addr,
  .cpu_wdata, .cpu_port_request_n, .cpu_rd_n, .cpu_wr_n, .cpu_opcode_fetch_n, .cpu_rdata,
  .cpu_rdata_oe_n, .cpu_wait_n, .cpu_nmi_n, .bus_in_strobe_n, .bus_out_strobe_n,
  .bus_ctrl_oe_n, .bus_data_in, .external_read_ack_n, .expansion_stall_n,
  .disk_completion_request, .disk_data_request, .external_bus_enable, .tape_output_level);

`default_nettype wire
